/* bench/fesr_mcu.sv */
`timescale 1ns/1ps
// =====
// Controller read-and-clear, no writes: reserved bits untouched
module fesr_mcu (
  input  wire logic mclk_i,
  input  wire logic go_i,
  output logic      rd_clr_o
);
  always_ff @(posedge mclk_i) rd_clr_o <= go_i;
endmodule // fesr_mcu

/* bench/fesr_props.sv */
`timescale 1ns/1ps
// =====
// Checks
module fesr_props (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        frame_sent_i,
  input wire logic        osc_fail_i,
  input wire logic [4:0]  osc_mon_i,
  input wire logic [8:0]  selective_wake_read_done_i,
  input wire logic        rd_clr_i,
  input wire logic [15:0] status_word_five_o,
  input wire logic        frame_detect_error_flag_o,
  input wire logic        system_error_indication_o,
  input wire logic        selective_wake_enable_o,
  input wire logic        wake_o
);
  logic [15:0] w;
  logic        f;
  assign w = status_word_five_o;
  assign f = frame_detect_error_flag_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_rsv; w[15:13] == 3'h0 && w[6:5] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_osc; osc_fail_i |=> w[7]; endproperty
  a_osc: assert property (p_osc) else $error("osc flag not set");
  property p_mon; frame_sent_i |=> w[4:0] == $past(osc_mon_i); endproperty
  a_mon: assert property (p_mon) else $error("monitor field wrong");
  property p_live; !frame_sent_i |=> $stable(w[12:8]); endproperty
  a_live: assert property (p_live) else $error("count moved");
  property p_fde; $fell(f) |-> $past(rd_clr_i); endproperty
  a_fde: assert property (p_fde) else $error("flag cleared early");
  property p_wake; wake_o |-> f ##1 !wake_o; endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_sys;
    system_error_indication_o == (w[7] | f | ~&selective_wake_read_done_i);
  endproperty
  a_sys: assert property (p_sys) else $error("system error wrong");
  property p_swen; system_error_indication_o |=> !selective_wake_enable_o; endproperty
  a_swen: assert property (p_swen) else $error("wake enable kept");
endmodule // fesr_props

/* bench/fesr_status_tb_top.sv */
`timescale 1ns/1ps
module fesr_status_tb_top;
  logic mclk_i = 1'b0, rst_i = 1'b1, g = 1'b0, b = 1'b0, s = 1'b0, of = 1'b0;
  logic en = 1'b1, go = 1'b0, wk = 1'b0, rc, fde, se, swen, wake;
  logic [4:0]  mon = 5'h00;
  logic [8:0]  rd = 9'h1FF;
  logic [15:0] w;
  int err_count = 0, n_tests = 0;
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (wake === 1'b1) wk <= 1'b1;
  fesr_status u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .frame_good_i(g), .frame_bad_i(b),
    .frame_sent_i(s), .osc_fail_i(of), .osc_mon_i(mon), .selective_wake_read_done_i(rd),
    .selective_wake_enable_req_i(en), .rd_clr_i(rc), .status_word_five_o(w),
    .frame_detect_error_flag_o(fde), .system_error_indication_o(se),
    .selective_wake_enable_o(swen), .wake_o(wake));
  fesr_mcu u_mcu (.mclk_i(mclk_i), .go_i(go), .rd_clr_o(rc));
  // =====
  // Tasks
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task ev(input logic gg, input logic bb, input logic ss);
    @(posedge mclk_i); g <= gg; b <= bb; s <= ss;
    @(posedge mclk_i); g <= 1'b0; b <= 1'b0; s <= 1'b0;
    #1;
  endtask
  task rdclr;
    @(posedge mclk_i); go <= 1'b1;
    @(posedge mclk_i); go <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task t_count;
    ev(1, 0, 0);
    repeat (3) ev(0, 1, 0);
    ev(1, 1, 0);
    ev(1, 0, 0);
    chk("live", w, 16'h0000);
    ev(0, 0, 1);
    chk("count", w, 16'h0300);
    $display("count test done");
  endtask
  task t_ovf;
    repeat (28) ev(0, 1, 0);
    ev(0, 0, 1);
    chk("full", w, 16'h1F00);
    chk("swen", swen, 16'h0001);
    ev(0, 1, 0);
    repeat (3) @(posedge mclk_i);
    #1;
    chk("fde", fde, 16'h0001);
    chk("wake", wk, 16'h0001);
    chk("sys", se, 16'h0001);
    chk("swen", swen, 16'h0000);
    ev(0, 0, 1);
    chk("zero", w, 16'h0000);
    rdclr;
    chk("fdeclr", fde, 16'h0000);
    @(posedge mclk_i);
    rd <= 9'h0FF;
    @(posedge mclk_i);
    #1;
    chk("unread", se, 16'h0001);
    rd <= 9'h1FF;
    @(posedge mclk_i);
    #1;
    chk("allread", se, 16'h0000);
    $display("overflow test done");
  endtask
  task t_osc;
    @(posedge mclk_i); of <= 1'b1; mon <= 5'h15;
    @(posedge mclk_i); of <= 1'b0;
    repeat (3) ev(0, 0, 0);
    ev(0, 0, 1);
    chk("osc", w, 16'h0095);
    rdclr;
    chk("oscclr", w, 16'h0015);
    $display("osc test done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_count;
    t_ovf;
    t_osc;
    finish_test;
  end
  initial begin
    #50000;
    err_count++;
    finish_test;
  end
endmodule // fesr_status_tb_top
bind fesr_status fesr_props u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .frame_sent_i(frame_sent_i), .osc_fail_i(osc_fail_i), .osc_mon_i(osc_mon_i),
  .selective_wake_read_done_i(selective_wake_read_done_i), .rd_clr_i(rd_clr_i),
  .status_word_five_o(status_word_five_o), .wake_o(wake_o),
  .frame_detect_error_flag_o(frame_detect_error_flag_o),
  .system_error_indication_o(system_error_indication_o),
  .selective_wake_enable_o(selective_wake_enable_o));

/* hw/fesr_counter.sv */
`timescale 1ns/1ps
`include "fesr_map.svh"
module fesr_counter (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  fesr_cnt_if.owner  cnt
);
  fesr_pkg::fesr_cnt_t cnt_r;
  fesr_pkg::fesr_cnt_t cnt_nxt;
  logic                ovf_r;
  logic                ovf_nxt;

  // ==========================================
  // Counter next state
  always_comb begin
    cnt_nxt = cnt_r;
    ovf_nxt = 1'b0;
    if (cnt.bad) begin
      if (cnt_r == `FESR_CNT_MAX) begin
        cnt_nxt = `FESR_CNT_ZERO; // [R4]
        ovf_nxt = 1'b1;           // [R4]
      end else begin
        cnt_nxt = cnt_r + 5'h01;  // [R2]
      end
    end else if (cnt.good) begin
      if (cnt_r != `FESR_CNT_ZERO) begin // [R11]
        cnt_nxt = cnt_r - 5'h01;         // [R3]
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= `FESR_CNT_ZERO;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign cnt.count    = cnt_r;
  assign cnt.overflow = ovf_r;
endmodule // fesr_counter

/* hw/fesr_status.sv */
`timescale 1ns/1ps
`include "fesr_map.svh"
// Function
// R1 - Count in bits 12..8, oscillator failure flag in bit 7.
// R2 - Bad frame (CRC, stuff, form error) increments the count.
// R3 - Each correctly decoded frame decrements the count (code: a good frame in the same cycle as a bad frame is ignored).
// R4 - Bad frame at count 31: wake, set detect error, clear count.
// R5 - Count and monitor field not shown live, refreshed after each sent frame.
// R6 - Oscillator failure flag latched until read-and-clear.
// R7 - Oscillator monitor value in bits 4..0.
// R8 - Controller leaves reserved bits at default.
// R9 - Detect error latched until read-and-clear, wakes from selective sleep.
// R10 - System error is OR of flags and unread wake regs; blocks wake enable.
// R11 - Count never decrements below zero.
module fesr_status (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        frame_good_i,
  input  wire logic        frame_bad_i,
  input  wire logic        frame_sent_i,
  input  wire logic        osc_fail_i,
  input  wire logic [4:0]  osc_mon_i,
  input  wire logic [8:0]  selective_wake_read_done_i,
  input  wire logic        selective_wake_enable_req_i,
  input  wire logic        rd_clr_i,
  output logic      [15:0] status_word_five_o,
  output logic             frame_detect_error_flag_o,
  output logic             system_error_indication_o,
  output logic             selective_wake_enable_o,
  output logic             wake_o
);
  fesr_cnt_if cnt_bus ();

  fesr_pkg::fesr_cnt_t cnt_shown_r;
  fesr_pkg::fesr_cnt_t cnt_shown_nxt;
  logic [4:0]          mon_r;
  logic [4:0]          mon_nxt;
  logic                osc_fail_r;
  logic                osc_fail_nxt;
  logic                fde_r;
  logic                fde_nxt;
  logic                wake_r;
  logic                wake_nxt;
  logic                swen_r;
  logic                swen_nxt;
  logic                system_error_indication;

  // ==========================================
  // Frame error counter
  assign cnt_bus.good = frame_good_i & ~frame_bad_i;
  assign cnt_bus.bad  = frame_bad_i;

  fesr_counter u_counter (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .cnt    (cnt_bus.owner)
  );

  // ==========================================
  // Fields refreshed per sent frame, flags updated every cycle
  assign system_error_indication = ~(&selective_wake_read_done_i) | osc_fail_r | fde_r; // [R10]

  always_comb begin
    cnt_shown_nxt = cnt_shown_r;
    mon_nxt       = mon_r;
    if (frame_sent_i) begin
      cnt_shown_nxt = cnt_bus.count; // [R5]
      mon_nxt       = osc_mon_i;     // [R5] [R7]
    end
    osc_fail_nxt = osc_fail_i | (osc_fail_r & ~rd_clr_i);     // [R6]
    fde_nxt      = cnt_bus.overflow | (fde_r & ~rd_clr_i);    // [R9]
    wake_nxt     = cnt_bus.overflow;                          // [R4] [R9]
    swen_nxt     = system_error_indication ? 1'b0 : selective_wake_enable_req_i; // [R10]
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_shown_r <= `FESR_CNT_ZERO;
      mon_r       <= `FESR_MON_RESET;
      osc_fail_r  <= 1'b0;
      fde_r       <= 1'b0;
      wake_r      <= 1'b0;
      swen_r      <= 1'b0;
    end else begin
      cnt_shown_r <= cnt_shown_nxt;
      mon_r       <= mon_nxt;
      osc_fail_r  <= osc_fail_nxt;
      fde_r       <= fde_nxt;
      wake_r      <= wake_nxt;
      swen_r      <= swen_nxt;
    end
  end

  // ==========================================
  // Status word, reserved bits at default
  always_comb begin
    status_word_five_o = `FESR_RSVD_DEFAULT;
    status_word_five_o[`FESR_CNT_MSB:`FESR_CNT_LSB] = cnt_shown_r; // [R1]
    status_word_five_o[`FESR_OSC_FAIL_BIT]          = osc_fail_r;  // [R1] [R6]
    status_word_five_o[`FESR_MON_MSB:`FESR_MON_LSB] = mon_r;       // [R7]
  end

  assign frame_detect_error_flag_o = fde_r;
  assign system_error_indication_o = system_error_indication;
  assign selective_wake_enable_o   = swen_r;
  assign wake_o                    = wake_r;
endmodule // fesr_status

/* pkg/fesr_cnt_if.sv */
`timescale 1ns/1ps
interface fesr_cnt_if;
  logic               good;
  logic               bad;
  fesr_pkg::fesr_cnt_t count;
  logic               overflow;
  modport owner (input good, input bad, output count, output overflow);
  modport user  (output good, output bad, input count, input overflow);
endinterface

/* pkg/fesr_map.svh */
`ifndef FESR_MAP_SVH
`define FESR_MAP_SVH
`define FESR_ADDR           6'h35
`define FESR_CNT_MSB        12
`define FESR_CNT_LSB        8
`define FESR_OSC_FAIL_BIT   7
`define FESR_MON_MSB        4
`define FESR_MON_LSB        0
`define FESR_CNT_MAX        5'h1F
`define FESR_CNT_ZERO       5'h00
`define FESR_MON_RESET      5'h00
`define FESR_RSVD_DEFAULT   16'h0000
`define FESR_SWRD_ALL       16'hFF80
`endif

/* pkg/fesr_pkg.sv */
package fesr_pkg;
  typedef logic [4:0]  fesr_cnt_t;
  typedef logic [15:0] fesr_word_t;
  typedef enum logic [1:0] {FESR_EV_NONE, FESR_EV_GOOD, FESR_EV_BAD} fesr_ev_t;
endpackage
